// >>> design/irc_pkg.sv
// Constants, register map and carrier types of the interrupt and reset controller.
// Assumes a single 10 MHz clock and an AXI4-Lite master with 32-bit data.
package irc_pkg;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PEND = 8'h04;
   localparam logic [7:0] OFS_ACT = 8'h08;
   localparam logic [7:0] OFS_P5 = 8'h0c;
   localparam logic [7:0] OFS_PMASK = 8'h10;
   localparam logic [7:0] OFS_MON = 8'h14;
   localparam logic [7:0] OFS_SYS = 8'h18;
   localparam logic [7:0] OFS_WDC = 8'h1c;
   localparam logic [7:0] OFS_WCLR = 8'h20;
   localparam logic [7:0] OFS_CAUSE = 8'h24;
   localparam logic [7:0] P5_RST = 8'h00;
   localparam logic [5:0] PMASK_RST = 6'h3f;
   localparam logic [3:0] MON_RST = 4'hf;
   localparam logic [3:0] SYS_RST = 4'hf;
   localparam int PM_SER = 0;
   localparam int PM_T1 = 1;
   localparam int PM_T2 = 2;
   localparam int PM_T3C1 = 3;
   localparam int PM_T3C2 = 4;
   localparam int PM_T3E = 5;
   localparam int MON_MASK = 0;
   localparam int SYS_BOT = 0;
   localparam int SYS_OS0 = 1;
   localparam int SYS_OS1 = 2;
   localparam int SYS_CCS = 3;
   localparam logic [2:0] MON_OFF = 3'h7;
   localparam logic [2:0] MON_EXT_NEG = 3'h6;
   localparam logic [2:0] MON_BAD_A = 3'h5;
   localparam logic [2:0] MON_EXT_POS = 3'h4;
   localparam logic [2:0] MON_BAD_B = 3'h0;
   localparam logic [7:0][11:0] VEC = {12'h1e0, 12'h1c0, 12'h180, 12'h140,
                                       12'h100, 12'h0c0, 12'h080, 12'h040};
   localparam logic [7:0] BOOT_OP = 8'hc1;
   localparam logic [11:0] BOOT_ADDR = 12'h008;
   localparam int RST_W = 5;
   localparam logic [RST_W-1:0] RST_HOLD = 5'h10;
   localparam int WD_W = 20;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] p5;
      logic p4_0;
      logic p4_3;
      logic mon_cmp;
      logic por;
      logic bod;
      logic clk_fail;
   } irc_pins_t;

   typedef struct packed {
      logic timer1;
      logic timer2;
      logic t3_cmp1;
      logic t3_cmp2;
      logic t3_edge;
      logic serial;
   } irc_evt_t;

   typedef struct packed {
      logic req;
      logic [2:0] level;
      logic [11:0] vector;
   } irc_irq_t;

   typedef struct packed {
      logic call;
      logic [7:0] opcode;
      logic [11:0] addr;
   } irc_boot_t;

   typedef struct packed {
      logic master_n;
      logic io_bus_rst;
      logic ports_input;
   } irc_rst_t;

   typedef struct packed {
      logic bod_low_sel;
      logic [2:0] mon_mode;
      logic clk_sup_en;
   } irc_ana_t;
endpackage

// >>> design/irc_top.sv
// Interrupt priority controller and master-reset sequencer with an AXI4-Lite register slave.
// Assumes core and peripheral strobes are on REF_CLK; PINS are asynchronous and are synchronised here.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module irc_top import irc_pkg::*; #(
   parameter logic [WD_W-1:0] WDOG_CYCLES = 20'h10000
) (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire irc_pins_t PINS,
   input wire irc_evt_t EVT,
   input wire logic NON_IO_CYCLE,
   input wire logic IRQ_ACK,
   input wire logic IRQ_RETURN,
   input wire logic POWER_DOWN,
   output irc_irq_t IRQ,
   output irc_boot_t BOOT,
   output irc_rst_t RST,
   output irc_ana_t ANA
);

   typedef struct packed {
      irc_pins_t s1;
      irc_pins_t s2;
      irc_pins_t prev;
      logic [7:0] pend;
      logic [7:0] act;
      logic [7:0] hold;
      logic gie;
      logic [7:0] p5_mode;
      logic [5:0] pmask;
      logic [3:0] mon;
      logic [3:0] sys;
      logic wd_en;
      logic [WD_W-1:0] wd_cnt;
      logic [RST_W-1:0] rst_cnt;
      logic por_phase;
      logic [3:0] cause;
      irc_irq_t irq;
      irc_boot_t boot;
      irc_rst_t rst;
      irc_ana_t ana;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic [7:0] aw_addr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } irc_state_t;

   irc_state_t s_r;
   irc_state_t s_nxt;

   // Returns {found, index} of the highest set bit.
   function automatic logic [3:0] top_bit(input logic [7:0] v);
      logic [3:0] t;
      t = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if (v[i]) begin
            t = {1'b1, 3'(i)};
         end
      end
      return t;
   endfunction

   // The monitor flag reads one while the monitor is off, matching its reset view.
   function automatic logic mon_flag(input logic [3:0] mon, input logic cmp);
      return (mon[3:1] == MON_OFF) ? 1'b1 : cmp;
   endfunction

   logic [7:0] req;
   logic [3:0] p5_rise;
   logic [3:0] p5_fall;
   logic [3:0] p5_hit;
   logic p4_edge;
   logic flag_now;
   logic flag_old;
   logic mon_valid;
   logic [3:0] best;
   logic [3:0] top_act;
   logic [7:0] sets;
   logic [7:0] clrs;
   logic sup_en;
   logic wd_trip;
   logic [3:0] trig_vec;
   logic trig;
   logic do_wr;
   logic wr_ok;
   logic [31:0] rd_val;
   logic rd_hit;

   always_comb begin
      s_nxt = s_r;
      req = 8'h00;
      sets = 8'h00;
      clrs = 8'h00;
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      wr_ok = 1'b1;

      s_nxt.s1 = PINS;
      s_nxt.s2 = s_r.s1;
      s_nxt.prev = s_r.s2;

      // Mode bit 0 of each input enables rising edges, bit 1 falling; both set gives any edge.
      p5_rise = s_r.s2.p5 & ~s_r.prev.p5;
      p5_fall = ~s_r.s2.p5 & s_r.prev.p5;
      for (int i = 0; i < 4; i++) begin
         p5_hit[i] = (s_r.p5_mode[2*i] & p5_rise[i]) | (s_r.p5_mode[2*i+1] & p5_fall[i]);
      end
      req[1] = p5_hit[2] | p5_hit[3];
      req[6] = p5_hit[0] | p5_hit[1];
      p4_edge = (s_r.s2.p4_0 ^ s_r.prev.p4_0) | (s_r.s2.p4_3 ^ s_r.prev.p4_3);
      req[3] = ~s_r.pmask[PM_SER] & (EVT.serial | p4_edge);
      req[2] = ~s_r.pmask[PM_T1] & EVT.timer1;
      req[4] = ~s_r.pmask[PM_T2] & EVT.timer2;
      req[5] = (~s_r.pmask[PM_T3C1] & EVT.t3_cmp1) | (~s_r.pmask[PM_T3C2] & EVT.t3_cmp2)
               | (~s_r.pmask[PM_T3E] & EVT.t3_edge);

      flag_now = mon_flag(s_r.mon, s_r.s2.mon_cmp);
      flag_old = mon_flag(s_r.mon, s_r.prev.mon_cmp);
      mon_valid = (s_r.mon[3:1] != MON_OFF) && (s_r.mon[3:1] != MON_BAD_A)
                  && (s_r.mon[3:1] != MON_BAD_B);
      if (!s_r.mon[MON_MASK] && mon_valid) begin
         if (s_r.mon[3:1] == MON_EXT_POS) begin
            req[7] = flag_now & ~flag_old;
         end else begin
            req[7] = ~flag_now & flag_old;
         end
      end

      // Requests seen during I/O cycles wait in the hold register for the next sample point.
      if (NON_IO_CYCLE) begin
         sets = s_r.hold | req;
         s_nxt.hold = 8'h00;
      end else begin
         s_nxt.hold = s_r.hold | req;
      end

      top_act = top_bit(s_r.act);
      if (IRQ_RETURN && top_act[3]) begin
         clrs[top_act[2:0]] = 1'b1;
      end
      if (IRQ_ACK && s_r.irq.req) begin
         s_nxt.act[s_r.irq.level] = 1'b1;
      end
      s_nxt.act = s_nxt.act & ~clrs;

      // AXI read channel: data is latched when the address is taken.
      case ({s_r.arready ? S_AXI_ARADDR[7:2] : 6'h00, 2'b00})
         OFS_CTRL: rd_val[0] = s_r.gie;
         OFS_PEND: rd_val[7:0] = s_r.pend;
         OFS_ACT: rd_val[7:0] = s_r.act;
         OFS_P5: rd_val[7:0] = s_r.p5_mode;
         OFS_PMASK: rd_val[5:0] = s_r.pmask;
         OFS_MON: rd_val[1:0] = {1'b1, flag_now};
         OFS_SYS: rd_val[3:0] = s_r.sys;
         OFS_WDC: rd_val[0] = s_r.wd_en;
         OFS_WCLR: rd_val[0] = 1'b0;
         OFS_CAUSE: rd_val[3:0] = s_r.cause;
         default: rd_hit = 1'b0;
      endcase
      if (s_r.arready && S_AXI_ARVALID) begin
         s_nxt.arready = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = rd_val;
         s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_r.rvalid && S_AXI_RREADY) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arready = 1'b1;
      end

      // Watchdog: a read of the clear address restarts the count.
      if (s_r.wd_en && !(s_r.arready && S_AXI_ARVALID && S_AXI_ARADDR[7:2] == OFS_WCLR[7:2])) begin
         s_nxt.wd_cnt = s_r.wd_cnt + 1'b1;
      end else begin
         s_nxt.wd_cnt = '0;
      end
      wd_trip = s_r.wd_en && (s_r.wd_cnt == WDOG_CYCLES - 1'b1);

      // AXI write channel: address and data may arrive in either order.
      if (s_r.awready && S_AXI_AWVALID) begin
         s_nxt.awready = 1'b0;
         s_nxt.aw_addr = S_AXI_AWADDR;
      end
      if (s_r.wready && S_AXI_WVALID) begin
         s_nxt.wready = 1'b0;
         s_nxt.wdata = S_AXI_WDATA;
         s_nxt.wstrb = S_AXI_WSTRB;
      end
      do_wr = !s_r.awready && !s_r.wready && !s_r.bvalid;
      if (do_wr) begin
         if (s_r.wstrb[0]) begin
            case ({s_r.aw_addr[7:2], 2'b00})
               OFS_CTRL: s_nxt.gie = s_r.wdata[0];
               OFS_PEND: sets = sets | s_r.wdata[7:0];
               OFS_P5: s_nxt.p5_mode = s_r.wdata[7:0];
               OFS_PMASK: s_nxt.pmask = s_r.wdata[5:0];
               OFS_MON: s_nxt.mon = s_r.wdata[3:0];
               OFS_SYS: s_nxt.sys = s_r.wdata[3:0];
               OFS_WDC: s_nxt.wd_en = s_r.wdata[0];
               OFS_ACT, OFS_WCLR, OFS_CAUSE: wr_ok = 1'b1;
               default: wr_ok = 1'b0;
            endcase
         end else begin
            case ({s_r.aw_addr[7:2], 2'b00})
               OFS_CTRL, OFS_PEND, OFS_ACT, OFS_P5, OFS_PMASK, OFS_MON, OFS_SYS, OFS_WDC, OFS_WCLR,
               OFS_CAUSE: wr_ok = 1'b1;
               default: wr_ok = 1'b0;
            endcase
         end
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_r.bvalid && S_AXI_BREADY) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready = 1'b1;
      end

      // A new request beats a return that clears the same level in the same cycle.
      s_nxt.pend = (s_r.pend & ~clrs) | sets;

      best = top_bit(s_r.pend);
      s_nxt.irq.req = s_r.gie && best[3] && (!top_act[3] || best[2:0] > top_act[2:0])
                      && !(IRQ_ACK && s_r.irq.req);
      s_nxt.irq.level = best[2:0];
      s_nxt.irq.vector = VEC[best[2:0]];

      sup_en = s_r.sys[SYS_OS1] && s_r.sys[SYS_OS0] && !s_r.sys[SYS_CCS];
      trig_vec = {s_r.s2.clk_fail && sup_en, wd_trip, s_r.s2.bod && !POWER_DOWN, s_r.s2.por};
      trig = |trig_vec;
      s_nxt.boot.call = 1'b0;
      s_nxt.boot.opcode = BOOT_OP;
      s_nxt.boot.addr = BOOT_ADDR;
      if (trig) begin
         s_nxt.rst_cnt = RST_HOLD;
         s_nxt.cause = trig_vec;
         s_nxt.por_phase = s_r.por_phase | s_r.s2.por;
      end else if (s_r.rst_cnt != '0) begin
         s_nxt.rst_cnt = s_r.rst_cnt - 1'b1;
         s_nxt.boot.call = (s_r.rst_cnt == RST_W'(1));
         if (s_r.rst_cnt == RST_W'(1)) begin
            s_nxt.por_phase = 1'b0;
         end
      end
      // The whole hold phase keeps the interrupt state cleared, not only its first cycle.
      if (trig || s_r.rst_cnt != '0) begin
         s_nxt.gie = 1'b0;
         s_nxt.pend = 8'h00;
         s_nxt.act = 8'h00;
         s_nxt.hold = 8'h00;
         s_nxt.wd_cnt = '0;
         s_nxt.irq.req = 1'b0;
      end
      s_nxt.rst.master_n = !(trig || (s_nxt.rst_cnt != '0));
      s_nxt.rst.io_bus_rst = s_nxt.por_phase;
      s_nxt.rst.ports_input = s_nxt.por_phase;
      s_nxt.ana.bod_low_sel = s_r.sys[SYS_BOT];
      s_nxt.ana.mon_mode = s_r.mon[3:1];
      s_nxt.ana.clk_sup_en = sup_en;
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_r <= '0;
         s_r.p5_mode <= P5_RST;
         s_r.pmask <= PMASK_RST;
         s_r.mon <= MON_RST;
         s_r.sys <= SYS_RST;
         s_r.rst_cnt <= RST_HOLD;
         s_r.por_phase <= 1'b1;
         s_r.rst.io_bus_rst <= 1'b1;
         s_r.rst.ports_input <= 1'b1;
         s_r.ana.bod_low_sel <= 1'b1;
         s_r.ana.mon_mode <= MON_OFF;
         s_r.boot.opcode <= BOOT_OP;
         s_r.boot.addr <= BOOT_ADDR;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign S_AXI_AWREADY = s_r.awready;
   assign S_AXI_WREADY = s_r.wready;
   assign S_AXI_BVALID = s_r.bvalid;
   assign S_AXI_BRESP = s_r.bresp;
   assign S_AXI_ARREADY = s_r.arready;
   assign S_AXI_RVALID = s_r.rvalid;
   assign S_AXI_RDATA = s_r.rdata;
   assign S_AXI_RRESP = s_r.rresp;
   assign IRQ = s_r.irq;
   assign BOOT = s_r.boot;
   assign RST = s_r.rst;
   assign ANA = s_r.ana;
endmodule // irc_top

// >>> test/irc_core_model.sv
// Core stand-in that runs the acknowledge cycle for a standing request.
// Assumes the controller drives its request from the same clock.
`timescale 1ns/1ps
module irc_core_model import irc_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire irc_irq_t irq,
   output logic ack
);
   logic [1:0] dly_r;
   // A slow core lets the request stand three cycles, as a busy core would.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_r <= 2'h0;
         ack <= 1'b0;
      end else begin
         ack <= 1'b0;
         dly_r <= 2'h0;
         if (irq.req && !ack) begin
            dly_r <= dly_r + 2'h1;
            ack <= !slow || dly_r == 2'h2;
         end
      end
   end
endmodule // irc_core_model

// >>> test/irc_top_assertions.sv
// Concurrent checks on the interrupt and reset controller outputs.
// Assumes it is bound to irc_top and sees only its ports.
`timescale 1ns/1ps
module irc_top_chk import irc_pkg::*; (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire irc_pins_t PINS,
   input wire logic IRQ_ACK,
   input wire irc_irq_t IRQ,
   input wire irc_boot_t BOOT,
   input wire irc_rst_t RST
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   property p_vec;
      IRQ.req |-> IRQ.vector == (IRQ.level == 3'h7 ? 12'h1e0 : {2'h0, {1'b0, IRQ.level} + 4'h1, 6'h00});
   endproperty
   a_vec: assert property (p_vec) else $error("vector does not match level");
   property p_boot;
      BOOT.call |-> BOOT.opcode == 8'hc1 && BOOT.addr == 12'h008;
   endproperty
   a_boot: assert property (p_boot) else $error("boot call payload wrong");
   property p_rel;
      $rose(RST.master_n) |-> BOOT.call;
   endproperty
   a_rel: assert property (p_rel) else $error("no boot call at release");
   property p_por;
      PINS.por [*5] |-> !RST.master_n;
   endproperty
   a_por: assert property (p_por) else $error("power-up did not reset");
   property p_hold;
      $fell(RST.master_n) |=> !RST.master_n [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("master reset too short");
   property p_io;
      RST.io_bus_rst |-> RST.ports_input && !RST.master_n;
   endproperty
   a_io: assert property (p_io) else $error("bus reset without port input mode");
   property p_clr;
      !RST.master_n ##1 !RST.master_n |-> !IRQ.req;
   endproperty
   a_clr: assert property (p_clr) else $error("request during master reset");
   property p_ack;
      IRQ_ACK && IRQ.req |=> !IRQ.req || IRQ.level > $past(IRQ.level);
   endproperty
   a_ack: assert property (p_ack) else $error("request stands after acknowledge");
endmodule // irc_top_chk

bind irc_top irc_top_chk i_chk (
   .REF_CLK(REF_CLK), .RESET_N(RESET_N), .PINS(PINS), .IRQ_ACK(IRQ_ACK),
   .IRQ(IRQ), .BOOT(BOOT), .RST(RST)
);

// >>> test/tb_interrupt_and_reset_control.sv
// Self-checking bench of the interrupt and reset controller through its register bus.
// Assumes the design package, the core stand-in and one 10 MHz clock.
`timescale 1ns/1ps
module tb_interrupt_and_reset_control import irc_pkg::*;;
   logic clk = 0, rst_n = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   irc_pins_t pins = '0;
   irc_evt_t evt = '0;
   logic nonio = 1, ret = 0, pd = 0, slow = 0, ack;
   irc_irq_t irq;
   irc_boot_t boot;
   irc_rst_t rst;
   irc_ana_t ana;
   int failures = 0, compares = 0, cyc = 0;
   logic [2:0] lv[3] = '{3'h7, 3'h5, 3'h0};
   always #50 clk = ~clk;
   irc_top #(.WDOG_CYCLES(20'h00040)) i_dut (.REF_CLK(clk), .RESET_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .PINS(pins), .EVT(evt), .NON_IO_CYCLE(nonio), .IRQ_ACK(ack),
      .IRQ_RETURN(ret), .POWER_DOWN(pd), .IRQ(irq), .BOOT(boot), .RST(rst), .ANA(ana));
   irc_core_model i_core (.clk(clk), .rst_n(rst_n), .slow(slow), .irq(irq), .ack(ack));
   task automatic complete_run;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ah, wh, bh;
      bh = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!bh) begin
         @(negedge clk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         if (bh) chk($sformatf("bresp %h", a), er, bresp);
         @(posedge clk);
         if (ah) awvalid <= 0;
         if (wh) wvalid <= 0;
      end
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ah, rh;
      rh = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      while (!rh) begin
         @(negedge clk);
         ah = arvalid && arready;
         rh = rvalid;
         if (rh) chk($sformatf("rdata %h", a), e, rdata);
         if (rh) chk($sformatf("rresp %h", a), er, rresp);
         @(posedge clk);
         if (ah) arvalid <= 0;
      end
      rready <= 0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input irc_evt_t e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '0;
   endtask
   task automatic ret_pulse;
      tick(4);
      ret <= 1;
      @(posedge clk);
      ret <= 0;
      tick(2);
   endtask
   task automatic wait_rst(input logic v);
      int n;
      n = 0;
      @(negedge clk);
      while (rst.master_n !== v && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk("master_n", v, rst.master_n);
   endtask
   // Waits for a request and checks its level and service address.
   task automatic irq_is(input logic [2:0] l);
      int n;
      n = 0;
      // Start off the clock edge so a request launched at this edge is not missed.
      @(negedge clk);
      while (irq.req !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("level", l, irq.level);
      chk("vector", l == 3'h7 ? 12'h1e0 : {2'h0, {1'b0, l} + 4'h1, 6'h00}, irq.vector);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         complete_run;
      end
   end
   initial begin
      tick(8);
      rst_n <= 1;
      chk("ana", 5'h1e, ana);
      rd(OFS_PMASK, 32'h3f, RESP_OKAY);
      rd(OFS_SYS, 32'hf, RESP_OKAY);
      rd(8'h40, 0, RESP_SLVERR);
      wr(8'h40, 1, RESP_SLVERR);
      wait_rst(1);
      wstrb <= 4'h0;
      wr(OFS_CTRL, 1, RESP_OKAY);
      wstrb <= 4'hf;
      rd(OFS_CTRL, 0, RESP_OKAY);
      wr(OFS_PMASK, 0, RESP_OKAY);
      wr(OFS_CTRL, 1, RESP_OKAY);
      nonio <= 0;
      pulse(6'h20);
      rd(OFS_PEND, 0, RESP_OKAY);
      nonio <= 1;
      irq_is(3'h2);
      tick(3);
      rd(OFS_ACT, 32'h4, RESP_OKAY);
      ret_pulse;
      rd(OFS_PEND, 0, RESP_OKAY);
      rd(OFS_ACT, 0, RESP_OKAY);
      wr(OFS_CTRL, 0, RESP_OKAY);
      pulse(6'h08);
      wr(OFS_PEND, 32'h81, RESP_OKAY);
      rd(OFS_PEND, 32'ha1, RESP_OKAY);
      chk("req", 0, irq.req);
      wr(OFS_CTRL, 1, RESP_OKAY);
      foreach (lv[i]) begin
         irq_is(lv[i]);
         tick(8);
         chk("req", 0, irq.req);
         // Only level 5, the second one, is served by a core that lets the request stand a while.
         slow <= (i == 0);
         ret_pulse;
      end
      wr(OFS_PMASK, 2, RESP_OKAY);
      pulse(6'h31);
      rd(OFS_PEND, 32'h18, RESP_OKAY);
      ret_pulse;
      ret_pulse;
      wr(OFS_PMASK, 32'h1a, RESP_OKAY);
      pulse(6'h05);
      pulse(6'h02);
      rd(OFS_PEND, 32'h28, RESP_OKAY);
      ret_pulse;
      ret_pulse;
      pins.p4_3 <= 1;
      tick(6);
      rd(OFS_PEND, 32'h08, RESP_OKAY);
      ret_pulse;
      wr(OFS_P5, 3, RESP_OKAY);
      pins.p5[0] <= 1;
      tick(6);
      rd(OFS_PEND, 32'h40, RESP_OKAY);
      ret_pulse;
      wr(OFS_P5, 0, RESP_OKAY);
      pins.p5[0] <= 0;
      tick(6);
      rd(OFS_PEND, 0, RESP_OKAY);
      wr(OFS_MON, 8, RESP_OKAY);
      pins.mon_cmp <= 1;
      tick(6);
      rd(OFS_MON, 3, RESP_OKAY);
      rd(OFS_PEND, 32'h80, RESP_OKAY);
      ret_pulse;
      wr(OFS_WDC, 1, RESP_OKAY);
      repeat (25) rd(OFS_WCLR, 0, RESP_OKAY);
      chk("master_n", 1, rst.master_n);
      wait_rst(0);
      wr(OFS_WDC, 0, RESP_OKAY);
      rd(OFS_CAUSE, 4, RESP_OKAY);
      rd(OFS_CTRL, 0, RESP_OKAY);
      wait_rst(1);
      pd <= 1;
      pins.bod <= 1;
      tick(20);
      chk("master_n", 1, rst.master_n);
      pd <= 0;
      wait_rst(0);
      rd(OFS_CAUSE, 2, RESP_OKAY);
      pins.bod <= 0;
      wait_rst(1);
      pins.clk_fail <= 1;
      tick(10);
      chk("master_n", 1, rst.master_n);
      wr(OFS_SYS, 6, RESP_OKAY);
      @(negedge clk);
      chk("sup", 1, ana.clk_sup_en);
      chk("ana", 5'h09, ana);
      wait_rst(0);
      wr(OFS_SYS, 32'hf, RESP_OKAY);
      pins.clk_fail <= 0;
      wait_rst(1);
      pins.por <= 1;
      tick(8);
      chk("rst", 3'h3, rst);
      pins.por <= 0;
      wait_rst(1);
      chk("boot", {1'b1, 8'hc1, 12'h008}, boot);
      chk("rst", 3'h4, rst);
      rd(OFS_CAUSE, 1, RESP_OKAY);
      complete_run;
   end
endmodule // tb_interrupt_and_reset_control
